//--- shared/indirect_access_params.svh
// Offsets, field positions, reset values and steps of the indirect access block.
// Assumes an APB slave with 32-bit words; each register index sits at byte address index*4.
`ifndef INDIRECT_ACCESS_PARAMS_SVH
`define INDIRECT_ACCESS_PARAMS_SVH

// Register indices (byte address is four times the index)
`define IDX_ANA_CTL 10'h040
`define IDX_ANA_OFF 10'h041
`define IDX_ANA_DAT 10'h042
`define IDX_IB_CTL 10'h048
`define IDX_IB_ADR0 10'h049
`define IDX_IB_ADR1 10'h04A
`define IDX_IB_DAT0 10'h04B
`define IDX_IB_DAT3 10'h04E

// Analog control fields
`define ANA_SEL_LSB 2
`define ANA_SEL_MSB 4
`define ANA_INC_BIT 1
`define ANA_RDS_BIT 0

// Internal-bus control fields
`define IB_TGT_LSB 3
`define IB_TGT_MSB 4
`define IB_INC_BIT 2
`define IB_RD_BIT 1
`define IB_EN_BIT 0

// Reset values and address steps
`define RST_BYTE 8'h00
`define ANA_STEP 8'h01
`define IB_STEP_CTRL 16'h0004
`define IB_STEP_OTHER 16'h0001

`endif

//--- shared/indirect_access_pkg.sv
// Types shared by the indirect access block and its bus engine.
// Assumes the constants header is included alongside.
package indirect_access_pkg;

  // Analog target select codes
  typedef enum logic [2:0] {
    ANA_OFF = 3'h0,
    ANA_CH0 = 3'h1,
    ANA_CH1 = 3'h2,
    ANA_CH2 = 3'h3,
    ANA_SHARE = 3'h4,
    ANA_LINK_TX = 3'h5,
    ANA_ALL_CH = 3'h6
  } ana_sel_t;

  // Internal-bus targets
  typedef enum logic [1:0] {
    IB_CTRL_BUS = 2'h0,
    IB_IDENT_SRAM = 2'h1,
    IB_CFG_DATA = 2'h2,
    IB_DIE_ID = 2'h3
  } ib_target_t;

  // Bus engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0,
    ENG_BUSY = 2'h1,
    ENG_DONE = 2'h2
  } eng_state_t;

endpackage : indirect_access_pkg

//--- verilog/internal_bus_engine.sv
// Request/acknowledge engine that runs one internal-bus access at a time.
// Assumes the far side answers ack_i on this clock, and holds rdata_i with it.
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_params.svh"

module internal_bus_engine import indirect_access_pkg::*; #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 32
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [1:0] target_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic ack_i,
  input wire logic [DATA_W-1:0] rdata_i,
  output logic req_o,
  output logic write_o,
  output logic [1:0] target_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic busy_o,
  output logic done_o
);

  eng_state_t state_q, state_d; // Engine phase
  logic req_d, write_d, busy_d, done_d; // Next values of flags
  logic [1:0] target_d;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] wdata_d, rdata_d;

  // Next-state logic: latch the request, hold it until acknowledged
  always_comb begin
    state_d = state_q;
    req_d = req_o;
    write_d = write_o;
    target_d = target_o;
    addr_d = addr_o;
    wdata_d = wdata_o;
    rdata_d = rdata_o;
    busy_d = busy_o;
    done_d = 1'b0;
    case (state_q)
      ENG_IDLE: begin
        // Latch everything so software may edit registers meanwhile
        if (start_i) begin
          req_d = 1'b1;
          write_d = write_i;
          target_d = target_i;
          addr_d = addr_i;
          wdata_d = wdata_i;
          busy_d = 1'b1;
          state_d = ENG_BUSY;
        end
      end
      ENG_BUSY: begin
        if (ack_i) begin
          req_d = 1'b0;
          if (!write_o) begin
            rdata_d = rdata_i;
          end
          done_d = 1'b1;
          state_d = ENG_DONE;
        end
      end
      ENG_DONE: begin
        // One idle cycle lets the owner clear its start request
        busy_d = 1'b0;
        state_d = ENG_IDLE;
      end
      default: begin
        req_d = 1'b0;
        busy_d = 1'b0;
        state_d = ENG_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ENG_IDLE;
      req_o <= 1'b0;
      write_o <= 1'b0;
      target_o <= 2'h0;
      addr_o <= '0;
      wdata_o <= '0;
      rdata_o <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      state_q <= state_d;
      req_o <= req_d;
      write_o <= write_d;
      target_o <= target_d;
      addr_o <= addr_d;
      wdata_o <= wdata_d;
      rdata_o <= rdata_d;
      busy_o <= busy_d;
      done_o <= done_d;
    end
  end

  // Request is held until acknowledged, then done follows one cycle later
  a_req_held: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (req_o && !ack_i) |=> req_o && $stable(addr_o)) else $error("request dropped early");
  a_done_after_ack: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (req_o && ack_i) |=> done_o ##1 !busy_o) else $error("done missing after ack");

endmodule : internal_bus_engine
`default_nettype wire

//--- verilog/indirect_register_access.sv
// Indirect register access block: analog indirect path and internal-bus window behind APB.
// Assumes APB on clk_i (50 MHz); analog and internal-bus targets run on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_params.svh"

module indirect_register_access import indirect_access_pkg::*; #(
  parameter int PADDR_W = 12
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [PADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [4:0] ana_chan_sel_o,
  output logic [7:0] ana_offset_o,
  output logic [7:0] ana_wdata_o,
  output logic ana_wr_o,
  output logic ana_rd_o,
  input wire logic [7:0] ana_rdata_i,
  output logic ib_req_o,
  output logic ib_write_o,
  output logic [1:0] ib_target_o,
  output logic [15:0] ib_addr_o,
  output logic [31:0] ib_wdata_o,
  output logic ib_busy_o,
  input wire logic ib_ack_i,
  input wire logic [31:0] ib_rdata_i
);

  // Address decode
  logic [9:0] idx; // Word index of the access
  logic aligned, mapped, setup, wr_acc, rd_acc;
  logic hit_actl, hit_aoff, hit_adat, hit_ictl, hit_adr0, hit_adr1;
  logic [3:0] hit_dat; // One per data byte

  // Software-visible state
  logic [2:0] ana_sel_q, ana_sel_d;
  logic ana_inc_q, ana_inc_d, ana_rds_q, ana_rds_d;
  logic [7:0] ana_off_d, ana_wdat_d;
  logic ana_wr_d, ana_rd_d;
  logic [4:0] chan_d; // Decoded analog block selects
  logic sel_valid; // Select holds a routable code
  logic ib_en_q, ib_en_d, ib_inc_q, ib_inc_d, ib_rd_q, ib_rd_d;
  logic [1:0] ib_tgt_q, ib_tgt_d;
  logic [15:0] ib_adr_q, ib_adr_d;
  logic [3:0][7:0] ib_dat_q, ib_dat_d;
  logic wr_pend_q, wr_pend_d; // Internal write waiting for the engine
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic [7:0] rbyte; // Byte returned by a read

  // Engine side
  logic eng_start, eng_done;
  logic [31:0] eng_rdata;

  assign idx = paddr_i[PADDR_W-1:2];
  assign aligned = (paddr_i[1:0] == 2'h0);
  assign hit_actl = aligned && (idx == `IDX_ANA_CTL);
  assign hit_aoff = aligned && (idx == `IDX_ANA_OFF);
  assign hit_adat = aligned && (idx == `IDX_ANA_DAT);
  assign hit_ictl = aligned && (idx == `IDX_IB_CTL);
  assign hit_adr0 = aligned && (idx == `IDX_IB_ADR0);
  assign hit_adr1 = aligned && (idx == `IDX_IB_ADR1);
  assign mapped = hit_actl || hit_aoff || hit_adat || hit_ictl || hit_adr0 || hit_adr1 || (|hit_dat);
  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_acc = psel_i && penable_i && pready_o && !pwrite_i;
  // Codes 7 and 0 route nowhere
  assign sel_valid = (ana_sel_q != ANA_OFF) && (ana_sel_q != 3'h7);

  // Per-channel select: own code or the broadcast code
  for (genvar g = 0; g < 4; g++) begin : g_dat_hit
    assign hit_dat[g] = aligned && (idx == `IDX_IB_DAT0 + 10'(g));
  end
  for (genvar c = 0; c < 3; c++) begin : g_chan
    assign chan_d[c] = (ana_sel_q == 3'(c + 1)) || (ana_sel_q == ANA_ALL_CH);
  end
  assign chan_d[3] = (ana_sel_q == ANA_SHARE);
  assign chan_d[4] = (ana_sel_q == ANA_LINK_TX);
  assign eng_start = ib_en_q && (ib_rd_q || wr_pend_q);

  // Read mux: analog data is sampled live from the selected block
  always_comb begin
    rbyte = 8'h00;
    if (hit_actl) begin
      rbyte = {3'h0, ana_sel_q, ana_inc_q, ana_rds_q};
    end else if (hit_aoff) begin
      rbyte = ana_offset_o;
    end else if (hit_adat) begin
      rbyte = sel_valid ? ana_rdata_i : 8'h00;
    end else if (hit_ictl) begin
      rbyte = {3'h0, ib_tgt_q, ib_inc_q, ib_rd_q, ib_en_q};
    end else if (hit_adr0) begin
      rbyte = ib_adr_q[7:0];
    end else if (hit_adr1) begin
      rbyte = ib_adr_q[15:8];
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (hit_dat[b]) begin
          rbyte = ib_dat_q[b];
        end
      end
    end
  end

  // Next values of all software-visible state
  always_comb begin
    ana_sel_d = ana_sel_q;
    ana_inc_d = ana_inc_q;
    ana_rds_d = ana_rds_q;
    ana_off_d = ana_offset_o;
    ana_wdat_d = ana_wdata_o;
    ana_wr_d = 1'b0;
    ana_rd_d = 1'b0;
    ib_en_d = ib_en_q;
    ib_inc_d = ib_inc_q;
    ib_rd_d = ib_rd_q;
    ib_tgt_d = ib_tgt_q;
    ib_adr_d = ib_adr_q;
    ib_dat_d = ib_dat_q;
    wr_pend_d = wr_pend_q;
    // Bus answer: one access cycle, data captured in the setup cycle
    pready_d = setup;
    pslverr_d = setup && !mapped;
    prdata_d = setup ? {24'h0, rbyte} : prdata_o;
    // Analog write strobe done: step past the written register
    if (ana_wr_o && ana_inc_q) begin
      ana_off_d = ana_offset_o + `ANA_STEP;
    end
    // Finished internal access: result, self-clear, address step
    if (eng_done) begin
      if (ib_write_o) begin
        wr_pend_d = 1'b0;
      end else begin
        ib_dat_d = eng_rdata;
        ib_rd_d = 1'b0;
      end
      if (ib_inc_q) begin
        ib_adr_d = ib_adr_q + ((ib_tgt_q == IB_CTRL_BUS) ? `IB_STEP_CTRL : `IB_STEP_OTHER);
      end
    end
    // Analog data read: step offset, then prefetch the next one
    if (rd_acc && hit_adat && sel_valid && ana_inc_q) begin
      ana_off_d = ana_offset_o + `ANA_STEP;
      ana_rd_d = ana_rds_q;
    end
    // Software writes come last so they win over hardware updates
    if (wr_acc) begin
      if (hit_actl) begin
        ana_sel_d = pwdata_i[`ANA_SEL_MSB:`ANA_SEL_LSB];
        ana_inc_d = pwdata_i[`ANA_INC_BIT];
        ana_rds_d = pwdata_i[`ANA_RDS_BIT];
      end
      if (hit_aoff) begin
        ana_off_d = pwdata_i[7:0];
        ana_rd_d = ana_rds_q && sel_valid;
      end
      if (hit_adat) begin
        ana_wdat_d = pwdata_i[7:0];
        ana_wr_d = sel_valid;
      end
      if (hit_ictl) begin
        ib_tgt_d = pwdata_i[`IB_TGT_MSB:`IB_TGT_LSB];
        ib_inc_d = pwdata_i[`IB_INC_BIT];
        ib_rd_d = pwdata_i[`IB_RD_BIT] || (ib_rd_q && !eng_done);
        ib_en_d = pwdata_i[`IB_EN_BIT];
      end
      if (hit_adr0) begin
        ib_adr_d[7:0] = pwdata_i[7:0];
      end
      if (hit_adr1) begin
        ib_adr_d[15:8] = pwdata_i[7:0];
      end
      for (int b = 0; b < 4; b++) begin
        if (hit_dat[b]) begin
          ib_dat_d[b] = pwdata_i[7:0];
        end
      end
      // Top data byte launches a write; the last two targets are read only
      if (hit_dat[3] && ib_en_q && !ib_tgt_q[1]) begin
        wr_pend_d = 1'b1;
      end
    end
  end

  // Register all state; control defaults to zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ana_sel_q <= 3'h0;
      ana_inc_q <= 1'b0;
      ana_rds_q <= 1'b0;
      ana_offset_o <= `RST_BYTE;
      ana_wdata_o <= `RST_BYTE;
      ana_wr_o <= 1'b0;
      ana_rd_o <= 1'b0;
      ana_chan_sel_o <= 5'h00;
      ib_en_q <= 1'b0;
      ib_inc_q <= 1'b0;
      ib_rd_q <= 1'b0;
      ib_tgt_q <= 2'h0;
      ib_adr_q <= 16'h0000;
      ib_dat_q <= 32'h00000000;
      wr_pend_q <= 1'b0;
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      ana_sel_q <= ana_sel_d;
      ana_inc_q <= ana_inc_d;
      ana_rds_q <= ana_rds_d;
      ana_offset_o <= ana_off_d;
      ana_wdata_o <= ana_wdat_d;
      ana_wr_o <= ana_wr_d;
      ana_rd_o <= ana_rd_d;
      ana_chan_sel_o <= chan_d;
      ib_en_q <= ib_en_d;
      ib_inc_q <= ib_inc_d;
      ib_rd_q <= ib_rd_d;
      ib_tgt_q <= ib_tgt_d;
      ib_adr_q <= ib_adr_d;
      ib_dat_q <= ib_dat_d;
      wr_pend_q <= wr_pend_d;
      prdata_o <= prdata_d;
      pready_o <= pready_d;
      pslverr_o <= pslverr_d;
    end
  end

  // Internal-bus engine; writes have priority over a pending read
  internal_bus_engine #(
    .ADDR_W(16),
    .DATA_W(32)
  ) u_engine (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .start_i(eng_start),
    .write_i(wr_pend_q),
    .target_i(ib_tgt_q),
    .addr_i(ib_adr_q),
    .wdata_i(ib_dat_q),
    .ack_i(ib_ack_i),
    .rdata_i(ib_rdata_i),
    .req_o(ib_req_o),
    .write_o(ib_write_o),
    .target_o(ib_target_o),
    .addr_o(ib_addr_o),
    .wdata_o(ib_wdata_o),
    .rdata_o(eng_rdata),
    .busy_o(ib_busy_o),
    .done_o(eng_done)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_ana_write: assert property ((wr_acc && hit_adat && sel_valid) |=>
    ana_wr_o && ana_wdata_o == $past(pwdata_i[7:0])) else $error("analog write strobe wrong");
  a_offset_prefetch: assert property ((wr_acc && hit_aoff && ana_rds_q && sel_valid) |=>
    ana_rd_o && ana_offset_o == $past(pwdata_i[7:0])) else $error("offset prefetch missing");
  a_read_prefetch: assert property ((rd_acc && hit_adat && sel_valid && ana_inc_q && ana_rds_q) |=>
    ana_rd_o && ana_offset_o == $past(ana_offset_o) + 8'h01) else $error("post-read strobe missing");
  a_write_step: assert property ((ana_wr_o && ana_inc_q) |=>
    ana_offset_o == $past(ana_offset_o) + 8'h01) else $error("offset not stepped");
  a_select_quiet: assert property (!sel_valid |=> !ana_wr_o && !ana_rd_o) else
    $error("strobe while analog select is off");
  a_broadcast_sel: assert property ((ana_sel_q == ANA_ALL_CH) |=> ana_chan_sel_o == 5'h07) else
    $error("broadcast select wrong");
  a_link_sel: assert property ((ana_sel_q == ANA_LINK_TX) |=> ana_chan_sel_o == 5'h10) else
    $error("transmitter select wrong");
  a_ana_readback: assert property ((setup && hit_adat && !pwrite_i) |=>
    prdata_o[7:0] == ($past(sel_valid) ? $past(ana_rdata_i) : 8'h00)) else $error("analog read data wrong");
  a_read_clear: assert property ((eng_done && !ib_write_o && !(wr_acc && (hit_ictl || (|hit_dat)))) |=>
    !ib_rd_q && ib_dat_q == $past(eng_rdata)) else $error("read bit or data not updated");
  a_ctrl_step: assert property ((eng_done && ib_inc_q && ib_tgt_q == IB_CTRL_BUS
    && !(wr_acc && (hit_adr0 || hit_adr1))) |=> ib_adr_q == $past(ib_adr_q) + 16'h0004) else
    $error("controller address step wrong");
  a_enable_gate: assert property ((!ib_en_q && !ib_busy_o) |=> !ib_req_o) else
    $error("internal request while disabled");
  a_read_only: assert property ((wr_acc && hit_dat[3] && ib_tgt_q[1] && !wr_pend_q) |=> !wr_pend_q) else
    $error("write to read-only target");

  c_prefetch_chain: cover property (rd_acc && hit_adat && ana_inc_q && ana_rds_q ##1 ana_rd_o);
  c_broadcast_write: cover property (ana_wr_o && ana_chan_sel_o == 5'h07);
  c_ib_read_done: cover property (eng_done && !ib_write_o && ib_inc_q);
  c_ib_write_done: cover property (eng_done && ib_write_o);

endmodule : indirect_register_access
`default_nettype wire

//--- dv/far_side_model.sv
// Far-side model: the analog register blocks and the internal-bus slave behind the block.
// Assumes strobes and requests come on the same clock; the slave answers after 1 to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [4:0] ana_chan_sel_i,
  input wire logic [7:0] ana_offset_i,
  input wire logic [7:0] ana_wdata_i,
  input wire logic ana_wr_i,
  output logic [7:0] ana_rdata_o,
  input wire logic ib_req_i,
  input wire logic ib_write_i,
  input wire logic [1:0] ib_target_i,
  input wire logic [15:0] ib_addr_i,
  input wire logic [31:0] ib_wdata_i,
  output logic ib_ack_o,
  output logic [31:0] ib_rdata_o
);
  logic [7:0] areg [5][256]; // Register files: ch0..ch2, shared, transmitter
  logic [31:0] ibm [logic [17:0]]; // Internal-bus words keyed by target and address
  logic [7:0] junk_q = 8'h00; // Changes every cycle and passes zero once in 256 cycles, so a stale read is seldom mistaken for zero
  logic wait_q; // A request has been seen and a delay drawn
  int cnt_q; // Cycles left before the acknowledge
  initial foreach (areg[b, o]) areg[b][o] = 8'h00;
  // Write strobe lands in every selected block at once
  always @(posedge clk_i) begin
    junk_q <= junk_q + 8'h5B;
    for (int b = 0; b < 5; b++) if (ana_wr_i && ana_chan_sel_i[b]) areg[b][ana_offset_i] <= ana_wdata_i;
  end
  // Lowest selected block answers; nothing selected gives changing junk
  always @* begin
    ana_rdata_o = junk_q;
    for (int b = 4; b >= 0; b--) if (ana_chan_sel_i[b]) ana_rdata_o = areg[b][ana_offset_i];
  end
  // Slave: random wait, one-cycle acknowledge, data valid only with it
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ib_ack_o <= 1'b0;
      wait_q <= 1'b0;
      cnt_q <= 0;
      ib_rdata_o <= 32'h0000_0000;
    end else begin
      ib_ack_o <= 1'b0;
      ib_rdata_o <= ~ib_rdata_o;
      if (ib_req_i && !ib_ack_o) begin
        if (!wait_q) begin
          wait_q <= 1'b1;
          cnt_q <= $urandom_range(3, 0);
        end else if (cnt_q == 0) begin
          ib_ack_o <= 1'b1;
          wait_q <= 1'b0;
          if (ib_write_i) ibm[{ib_target_i, ib_addr_i}] = ib_wdata_i;
          else ib_rdata_o <= ibm.exists({ib_target_i, ib_addr_i}) ? ibm[{ib_target_i, ib_addr_i}]
                             : {14'h0000, ib_target_i, ib_addr_i};
        end else begin
          cnt_q <= cnt_q - 1;
        end
      end
    end
  end
endmodule : far_side_model
`default_nettype wire

//--- dv/tb_indirect_register_access.sv
// Self-checking bench for the indirect register access block, driven over APB.
// Assumes the far-side model stands on the analog and internal-bus ports.
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_params.svh"
module tb_indirect_register_access import indirect_access_pkg::*;;
  logic clk_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, ib_wdata_o, ib_rdata_i;
  logic pready_o, pslverr_o, ana_wr_o, ana_rd_o, ib_req_o, ib_write_o, ib_busy_o, ib_ack_i;
  logic [4:0] ana_chan_sel_o;
  logic [7:0] ana_offset_o, ana_wdata_o, ana_rdata_i;
  logic [1:0] ib_target_o;
  logic [15:0] ib_addr_o;
  int error_cnt = 0, num_checks = 0, cyc = 0, wr_cnt = 0, rd_cnt = 0, ib_cnt = 0;
  logic [7:0] last_wdat, last_woff; // Captured analog write strobe
  logic [4:0] last_wsel;
  logic [34:0] ib_last; // Captured target, address and direction of the last access
  logic [31:0] ib_lwd;
  logic [7:0] sh [5][256]; // Expected analog register contents
  logic [9:0] ridx [10] = '{10'h040, 10'h041, 10'h042, 10'h048, 10'h049, 10'h04A, 10'h04B, 10'h04C,
                            10'h04D, 10'h04E};
  always #10 clk_i = ~clk_i;
  indirect_register_access dut (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .ana_chan_sel_o, .ana_offset_o, .ana_wdata_o, .ana_wr_o, .ana_rd_o,
    .ana_rdata_i, .ib_req_o, .ib_write_o, .ib_target_o, .ib_addr_o, .ib_wdata_o, .ib_busy_o, .ib_ack_i,
    .ib_rdata_i);
  far_side_model far (.clk_i, .arst_n_i, .ana_chan_sel_i(ana_chan_sel_o), .ana_offset_i(ana_offset_o),
    .ana_wdata_i(ana_wdata_o), .ana_wr_i(ana_wr_o), .ana_rdata_o(ana_rdata_i), .ib_req_i(ib_req_o),
    .ib_write_i(ib_write_o), .ib_target_i(ib_target_o), .ib_addr_i(ib_addr_o), .ib_wdata_i(ib_wdata_o),
    .ib_ack_o(ib_ack_i), .ib_rdata_o(ib_rdata_i));
  // Monitor: count strobes and keep what each write strobe and internal access carried
  always @(posedge clk_i) begin
    cyc++;
    if (ana_wr_o === 1'b1) begin
      wr_cnt++;
      {last_wsel, last_woff, last_wdat} = {ana_chan_sel_o, ana_offset_o, ana_wdata_o};
    end
    if (ana_rd_o === 1'b1) rd_cnt++;
    if (ib_req_o === 1'b1 && ib_ack_i === 1'b1) begin
      ib_cnt++;
      ib_last = {14'h0, ib_target_o, ib_addr_o, ib_write_o};
      ib_lwd = ib_wdata_o;
    end
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [34:0] e, input logic [34:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {i, 2'b00};
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    // No limit of its own: only the bench timeout ends a wait for pready
    while (pready_o !== 1'b1) begin
      @(posedge clk_i);
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
    chk("write_err", 35'h0, {34'h0, e});
  endtask : wr
  task automatic rd(input logic [9:0] i, output logic [31:0] r);
    logic e;
    apb(1'b0, i, 8'h00, r, e);
    chk("read_err", 35'h0, {34'h0, e});
  endtask : rd
  task automatic rdaddr(output logic [31:0] v);
    logic [31:0] l, h;
    rd(`IDX_IB_ADR0, l);
    rd(`IDX_IB_ADR1, h);
    v = {16'h0, h[7:0], l[7:0]};
  endtask : rdaddr
  // Select code to block enables; code 6 enables the three channels at once
  function automatic logic [4:0] dec(input logic [2:0] s);
    case (s)
      3'h1: return 5'h01;
      3'h2: return 5'h02;
      3'h3: return 5'h04;
      3'h4: return 5'h08;
      3'h5: return 5'h10;
      3'h6: return 5'h07;
      default: return 5'h00;
    endcase
  endfunction : dec
  initial begin
    logic [31:0] r, w, v;
    logic [15:0] a;
    logic [7:0] o, d;
    logic [4:0] m;
    logic e;
    int n0, n;
    foreach (sh[b, x]) sh[b][x] = 8'h00;
    void'($urandom(13802));
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // Reset values, then an unmapped index is refused
    foreach (ridx[k]) begin
      rd(ridx[k], r);
      chk("reset_value", 35'h0, r);
    end
    apb(1'b0, 10'h050, 8'h00, r, e);
    chk("unmapped", 35'h1, {r, e});
    // Every select code: decode, write strobes with auto-increment, read-back
    for (int s = 0; s < 8; s++) begin
      m = dec(s[2:0]);
      wr(`IDX_ANA_CTL, {3'h0, s[2:0], 2'b10});
      repeat (2) @(posedge clk_i);
      chk("chan_sel", m, ana_chan_sel_o);
      o = 8'($urandom);
      n0 = wr_cnt;
      wr(`IDX_ANA_OFF, o);
      for (int k = 0; k < 2; k++) begin
        d = 8'($urandom);
        wr(`IDX_ANA_DAT, d);
        repeat (2) @(posedge clk_i);
        if (m != 5'h00) begin
          for (int b = 0; b < 5; b++) if (m[b]) sh[b][8'(o + k)] = d;
          chk("ana_write", {m, 8'(o + k), d}, {last_wsel, last_woff, last_wdat});
        end
      end
      chk("write_count", n0 + ((m != 5'h00) ? 2 : 0), wr_cnt);
      rd(`IDX_ANA_OFF, r);
      // A disabled select issues no access, so the offset must not move
      chk("offset_step", (m != 5'h00) ? 8'(o + 2) : o, r);
      wr(`IDX_ANA_OFF, o);
      for (int k = 0; k < 2; k++) begin
        rd(`IDX_ANA_DAT, r);
        chk("ana_read", (m != 5'h00) ? sh[(s == 6) ? 0 : s - 1][8'(o + k)] : 8'h00, r);
      end
    end
    chk("no_prefetch", 35'h0, rd_cnt);
    // Read-start prefetch on offset write and on data read
    wr(`IDX_ANA_CTL, 8'h13);
    n0 = rd_cnt;
    wr(`IDX_ANA_OFF, 8'($urandom));
    repeat (2) @(posedge clk_i);
    chk("strobe_offset", n0 + 1, rd_cnt);
    rd(`IDX_ANA_DAT, r);
    repeat (2) @(posedge clk_i);
    chk("strobe_data", n0 + 2, rd_cnt);
    wr(`IDX_ANA_CTL, 8'h11);
    rd(`IDX_ANA_DAT, r);
    repeat (2) @(posedge clk_i);
    chk("strobe_noinc", n0 + 2, rd_cnt);
    // Internal bus: targets 0 and 1 written, 2 and 3 refuse the write; each then read, auto-increment on
    for (int t = 0; t < 4; t++) begin
      a = 16'($urandom);
      w = $urandom;
      n0 = ib_cnt;
      wr(`IDX_IB_CTL, {3'h0, t[1:0], 3'b101});
      wr(`IDX_IB_ADR0, a[7:0]);
      wr(`IDX_IB_ADR1, a[15:8]);
      for (int k = 0; k < 4; k++) wr(10'(`IDX_IB_DAT0 + k), w[8 * k +: 8]);
      repeat (3) @(posedge clk_i);
      n = 0;
      while (ib_busy_o !== 1'b0 && n < 40) begin
        @(posedge clk_i);
        n++;
      end
      chk("ib_wcount", n0 + ((t < 2) ? 1 : 0), ib_cnt);
      if (t < 2) begin
        chk("ib_wreq", {t[1:0], a, 1'b1}, ib_last[18:0]);
        chk("ib_wdata", w, ib_lwd);
      end
      rdaddr(v);
      chk("ib_wstep", (t < 2) ? 16'(a + ((t == 0) ? 4 : 1)) : a, v);
      wr(`IDX_IB_ADR0, a[7:0]);
      wr(`IDX_IB_ADR1, a[15:8]);
      wr(`IDX_IB_CTL, {3'h0, t[1:0], 3'b111});
      n = 0;
      do begin
        rd(`IDX_IB_CTL, r);
        n++;
      end while (r[1] !== 1'b0 && n < 30);
      chk("read_bit", 35'h0, r[1]);
      chk("ib_rreq", {t[1:0], a, 1'b0}, ib_last[18:0]);
      for (int k = 0; k < 4; k++) begin
        rd(10'(`IDX_IB_DAT0 + k), r);
        v[8 * k +: 8] = r[7:0];
      end
      chk("ib_rdata", (t < 2) ? w : {14'h0, t[1:0], a}, v);
      rdaddr(v);
      chk("ib_rstep", 16'(a + ((t == 0) ? 4 : 1)), v);
    end
    // Disabled interface starts nothing
    n0 = ib_cnt;
    wr(`IDX_IB_CTL, 8'h02);
    repeat (10) @(posedge clk_i);
    chk("ib_disabled", {n0, 1'b0}, {ib_cnt, ib_busy_o});
    end_sim();
  end
endmodule : tb_indirect_register_access
`default_nettype wire
